// File: hdl/csr_defs.vh
// Constants for the charger status register bank.
// Assumes inclusion by the bank module only; definitions only.
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH

`define CSR_ADDR_W 8
`define CSR_ADDR_STAT0 8'h08
`define CSR_ADDR_FAULT 8'h09
`define CSR_ADDR_STAT2 8'h0a
`define CSR_ADDR_PART 8'h0b

`define CSR_SRC_NONE 3'h0
`define CSR_SRC_SDP 3'h1
`define CSR_SRC_ADAPTER 3'h3
`define CSR_SRC_BOOST 3'h7

`define CSR_PHASE_IDLE 2'h0
`define CSR_PHASE_PRE 2'h1
`define CSR_PHASE_FAST 2'h2
`define CSR_PHASE_DONE 2'h3

`define CSR_ERR_NONE 2'h0
`define CSR_ERR_INPUT 2'h1
`define CSR_ERR_THERMAL 2'h2
`define CSR_ERR_TIMER 2'h3

`define CSR_TS_NORMAL 3'h0
`define CSR_TS_WARM 3'h2
`define CSR_TS_COOL 3'h3
`define CSR_TS_COLD 3'h5
`define CSR_TS_HOT 3'h6

`define CSR_BIT_VMASK 1
`define CSR_BIT_IMASK 0
`define CSR_BIT_REGRST 7
`define CSR_MASK_RESET 2'h0
`define CSR_PART_LOW_RESET 3'h4

`endif

// File: hdl/csr_charger_status_register_bank.v
// Charger status register bank: status 0, fault status, status 2 with
// two interrupt masks, and part information with a register reset bit.
// Assumes condition inputs come from analog blocks on other clocks and
// a simple register port (addr, write strobe, read strobe) on sys_clk_in.
`timescale 1ns/1ps
`include "csr_defs.vh"

module csr_charger_status_register_bank #(
    parameter ADDR_W = `CSR_ADDR_W,
    parameter [3:0] PART_NUMBER = 4'h0  // Arbitrary value
) (
    // Clock and reset
    input wire sys_clk_in,
    input wire rstn_in,
    // Register port
    input wire [ADDR_W-1:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_wdata_in,
    output reg [7:0] reg_rdata_out,
    output reg reg_rvalid_out,
    // Source conditions
    input wire input_present_in,
    input wire boost_active_in,
    input wire source_select_pin_in,
    // Charger conditions
    input wire [1:0] charge_phase_in,
    input wire power_good_in,
    input wire thermal_regulation_in,
    input wire system_minimum_in,
    input wire watchdog_expired_in,
    input wire boost_overload_in,
    input wire boost_battery_low_in,
    input wire input_fault_in,
    input wire thermal_shutdown_in,
    input wire safety_timer_expired_in,
    input wire battery_overvoltage_in,
    input wire [2:0] thermistor_zone_in,
    // Input loop conditions
    input wire input_qualified_in,
    input wire input_voltage_loop_in,
    input wire input_current_loop_in,
    input wire sense_pin_fault_in,
    input wire topoff_timer_running_in,
    input wire input_overvoltage_in,
    // Outputs to the charger core
    output reg irq_pulse_out,
    output reg safety_timer_restart_out,
    output reg register_reset_out
);

    localparam NSYNC = 21;
    // Watchdog stage idles at its expired level, so the flag cannot dip to
    // 0 for the two cycles after reset while the chain fills
    localparam WDOG_POS = 12;
    localparam [NSYNC-1:0] SYNC_RESET = {{(NSYNC-1){1'h0}}, 1'h1} << WDOG_POS;

    // Register addresses at the port width
    localparam [ADDR_W-1:0] A_STAT0 = `CSR_ADDR_STAT0;
    localparam [ADDR_W-1:0] A_FAULT = `CSR_ADDR_FAULT;
    localparam [ADDR_W-1:0] A_STAT2 = `CSR_ADDR_STAT2;
    localparam [ADDR_W-1:0] A_PART = `CSR_ADDR_PART;

    ////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for all live conditions

    wire [NSYNC-1:0] raw_cond;
    reg [NSYNC-1:0] sync_a;
    reg [NSYNC-1:0] sync_b;

    assign raw_cond = {
        input_present_in,
        boost_active_in,
        source_select_pin_in,
        charge_phase_in,
        power_good_in,
        thermal_regulation_in,
        system_minimum_in,
        watchdog_expired_in,
        boost_overload_in,
        boost_battery_low_in,
        input_fault_in,
        thermal_shutdown_in,
        safety_timer_expired_in,
        battery_overvoltage_in,
        input_qualified_in,
        input_voltage_loop_in,
        input_current_loop_in,
        sense_pin_fault_in,
        topoff_timer_running_in,
        input_overvoltage_in
    };

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge sys_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    sync_a[gi] <= SYNC_RESET[gi];
                    sync_b[gi] <= SYNC_RESET[gi];
                end else begin
                    sync_a[gi] <= raw_cond[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    // Thermistor code is multi-bit; synchronise it as a group
    reg [2:0] zone_a;
    reg [2:0] zone_b;

    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            zone_a <= 3'h0;
            zone_b <= 3'h0;
        end else begin
            zone_a <= thermistor_zone_in;
            zone_b <= zone_a;
        end
    end

    wire s_present = sync_b[20];
    wire s_boost = sync_b[19];
    wire s_psel = sync_b[18];
    wire [1:0] phase_sync = sync_b[17:16];
    wire s_pg = sync_b[15];
    wire s_therm = sync_b[14];
    wire s_sysmin = sync_b[13];
    wire s_wdog = sync_b[WDOG_POS];
    wire s_bst_ovl = sync_b[11];
    wire s_boost_battery_low = sync_b[10];
    wire s_in_fault = sync_b[9];
    wire s_tshut = sync_b[8];
    wire s_stimer = sync_b[7];
    wire s_bat_ov = sync_b[6];
    wire s_qual = sync_b[5];
    wire s_vloop = sync_b[4];
    wire s_iloop = sync_b[3];
    wire s_sense = sync_b[2];
    wire s_topoff = sync_b[1];
    wire s_input_overvoltage = sync_b[0];

    ////////////////////////////////////////////////////////////////////
    // Multi-bit codes: bits of one code may cross on different edges and
    // show a mixed value for a cycle, so a code is taken only once it has
    // been seen on two edges in a row; this costs two extra cycles

    wire [4:0] code_sync = {phase_sync, zone_b};
    reg [4:0] code_prev;
    reg [4:0] code_held;

    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            code_prev <= 5'h00;
            code_held <= 5'h00;
        end else begin
            code_prev <= code_sync;
            if (code_sync == code_prev) begin
                code_held <= code_sync;
            end
        end
    end

    wire [1:0] s_phase = code_held[4:3];
    wire [2:0] s_zone = code_held[2:0];

    ////////////////////////////////////////////////////////////////////
    // Live status bytes

    reg [2:0] source_code;
    reg [1:0] error_code;
    reg [2:0] zone_code;
    // Watchdog flag reads 1 from power-on until the core reports host mode
    reg wdog_seen_host;

    always @* begin
        // Boost wins over an input source; a current limit set by software
        // never alters this code
        if (s_boost) begin
            source_code = `CSR_SRC_BOOST;
        end else if (!s_present) begin
            source_code = `CSR_SRC_NONE;
        end else if (s_psel) begin
            source_code = `CSR_SRC_SDP;
        end else begin
            source_code = `CSR_SRC_ADAPTER;
        end
    end

    always @* begin
        // Priority keeps the most severe fault visible
        if (s_tshut) begin
            error_code = `CSR_ERR_THERMAL;
        end else if (s_stimer) begin
            error_code = `CSR_ERR_TIMER;
        end else if (s_in_fault) begin
            error_code = `CSR_ERR_INPUT;
        end else begin
            error_code = `CSR_ERR_NONE;
        end
    end

    always @* begin
        if (s_boost) begin
            // Warm and cool are not meaningful in boost
            case (s_zone)
                `CSR_TS_COLD: zone_code = `CSR_TS_COLD;
                `CSR_TS_HOT: zone_code = `CSR_TS_HOT;
                default: zone_code = `CSR_TS_NORMAL;
            endcase
        end else begin
            case (s_zone)
                `CSR_TS_WARM: zone_code = `CSR_TS_WARM;
                `CSR_TS_COOL: zone_code = `CSR_TS_COOL;
                `CSR_TS_COLD: zone_code = `CSR_TS_COLD;
                `CSR_TS_HOT: zone_code = `CSR_TS_HOT;
                default: zone_code = `CSR_TS_NORMAL;
            endcase
        end
    end

    wire [7:0] charger_status_primary = {source_code, s_phase, s_pg, s_therm,
                                         s_sysmin};
    wire [7:0] charger_fault_status = {~wdog_seen_host, s_bst_ovl | s_boost_battery_low,
                                       error_code, s_bat_ov, zone_code};
    reg [1:0] irq_masks;
    wire [7:0] charger_status_secondary = {s_qual, s_vloop, s_iloop, s_sense,
                                           s_topoff, s_input_overvoltage, irq_masks};
    wire [7:0] part_information = {1'b0, PART_NUMBER, `CSR_PART_LOW_RESET};

    ////////////////////////////////////////////////////////////////////
    // Watchdog flag: set at power-on and on expiry, cleared in host mode

    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wdog_seen_host <= 1'h0;
        end else begin
            wdog_seen_host <= ~s_wdog;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Writable bits

    wire wr_stat2 = reg_wr_in && (reg_addr_in == A_STAT2);
    wire wr_reset = reg_wr_in && (reg_addr_in == A_PART) &&
                    reg_wdata_in[`CSR_BIT_REGRST];

    // A reset write wins over a mask write landing in the same cycle
    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_masks <= `CSR_MASK_RESET;
            register_reset_out <= 1'h0;
            safety_timer_restart_out <= 1'h0;
        end else begin
            // Reset bit self-clears: it never holds, so it reads back 0
            register_reset_out <= wr_reset;
            safety_timer_restart_out <= wr_reset;
            if (wr_reset) begin
                irq_masks <= `CSR_MASK_RESET;
            end else if (wr_stat2) begin
                // Only the two mask bits take write data
                irq_masks <= reg_wdata_in[`CSR_BIT_VMASK:`CSR_BIT_IMASK];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt pulses on entry into a regulation loop

    // Edge detectors reset low, the idle level of the loop flags, so no
    // false pulse follows reset
    reg vloop_d;
    reg iloop_d;

    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            vloop_d <= 1'h0;
            iloop_d <= 1'h0;
            irq_pulse_out <= 1'h0;
        end else begin
            vloop_d <= s_vloop;
            iloop_d <= s_iloop;
            irq_pulse_out <= (s_vloop & ~vloop_d & ~irq_masks[`CSR_BIT_VMASK]) |
                             (s_iloop & ~iloop_d & ~irq_masks[`CSR_BIT_IMASK]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read port: one-cycle latency, no side effects

    reg [7:0] next_rdata;

    always @* begin
        case (reg_addr_in)
            A_STAT0: next_rdata = charger_status_primary;
            A_FAULT: next_rdata = charger_fault_status;
            A_STAT2: next_rdata = charger_status_secondary;
            A_PART: next_rdata = part_information;
            // Unmapped addresses read as zero
            default: next_rdata = 8'h00;
        endcase
    end

    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= next_rdata;
            end
        end
    end

endmodule // csr_charger_status_register_bank

// File: tb/csr_bank_properties.sv
// Assertions on the charger status register bank ports.
// Assumes a bind into the bank; one clock, async active-low reset.
`timescale 1ns/1ps
module csr_bank_properties #(
    parameter ADDR_W = 8
) (
    input wire sys_clk_in,
    input wire rstn_in,
    input wire [ADDR_W-1:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_wdata_in,
    input wire [7:0] reg_rdata_out,
    input wire reg_rvalid_out,
    input wire input_voltage_loop_in,
    input wire input_current_loop_in,
    input wire irq_pulse_out,
    input wire safety_timer_restart_out,
    input wire register_reset_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    wire loop_any = input_voltage_loop_in || input_current_loop_in;
    // Mirror of the two mask bits, followed from the writes on the port
    logic [1:0] seen_mask;
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) seen_mask <= 2'h0;
        else if (reg_wr_in && reg_addr_in == 8'h0b && reg_wdata_in[7]) seen_mask <= 2'h0;
        else if (reg_wr_in && reg_addr_in == 8'h0a) seen_mask <= reg_wdata_in[1:0];
    end
    sequence s_reset_wr;
        reg_wr_in && reg_addr_in == 8'h0b && reg_wdata_in[7];
    endsequence
    sequence s_reset_pulse;
        register_reset_out && safety_timer_restart_out ##1 !register_reset_out;
    endsequence
    a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered");
    a_no_stray_valid: assert property (!reg_rd_in |=> !reg_rvalid_out)
        else $error("valid without read");
    a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved without read");
    a_reset_steps: assert property (s_reset_wr |=> s_reset_pulse)
        else $error("register reset pulse wrong");
    a_reset_cause: assert property ($rose(register_reset_out) |-> $past(reg_wr_in))
        else $error("register reset without write");
    a_pulses_paired: assert property (register_reset_out == safety_timer_restart_out)
        else $error("reset pulses differ");
    a_part_bit_low: assert property (reg_rd_in && reg_addr_in == 8'h0b |=> !reg_rdata_out[7])
        else $error("reset bit reads one");
    a_irq_cause: assert property (irq_pulse_out |-> $past(loop_any, 2) || $past(loop_any, 3))
        else $error("interrupt without loop flag");
    a_irq_single: assert property (irq_pulse_out |=> !irq_pulse_out)
        else $error("interrupt longer than one cycle");
    a_irq_unmasked: assert property (irq_pulse_out |->
        ($past(input_voltage_loop_in, 3) && !$past(input_voltage_loop_in, 4)
            && !$past(seen_mask[1]))
        || ($past(input_current_loop_in, 3) && !$past(input_current_loop_in, 4)
            && !$past(seen_mask[0])))
        else $error("interrupt despite mask");
endmodule // csr_bank_properties

// File: tb/csr_host_model.sv
// Host side of the register port: strobed reads and writes.
// Assumes calls start just after a rising edge of sys_clk_in.
`timescale 1ns/1ps
module csr_host_model (
    // Clock
    input wire sys_clk_in,
    // Register port, host side
    output logic [7:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] wdata_out,
    input wire [7:0] rdata_in,
    input wire rvalid_in
);
    initial begin
        {addr_out, wr_out, rd_out, wdata_out} = 18'h0;
    end
    // Idle lines show inverted values so stale data is never mistaken for live
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        {addr_out, wdata_out, wr_out} = {a, d, 1'h1};
        @(posedge sys_clk_in) #1;
        {addr_out, wdata_out, wr_out} = {~a, ~d, 1'h0};
        @(posedge sys_clk_in) #1;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        int n;
        {addr_out, rd_out} = {a, 1'h1};
        @(posedge sys_clk_in) #1;
        {addr_out, rd_out} = {~a, 1'h0};
        for (n = 0; n < 4 && rvalid_in !== 1'h1; n++) @(posedge sys_clk_in) #1;
        d = rdata_in;
        @(posedge sys_clk_in) #1;
    endtask
endmodule // csr_host_model

// File: tb/testbench.sv
// Self-checking bench for the charger status register bank.
// Assumes the host model drives the register port; conditions driven here.
`timescale 1ns/1ps
module testbench;
    logic sys_clk_in = 1'h0, rstn_in = 1'h0;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, got;
    logic reg_wr_in, reg_rd_in, reg_rvalid_out;
    logic input_present_in = 1'h0, boost_active_in = 1'h0, source_select_pin_in = 1'h0;
    logic [1:0] charge_phase_in = 2'h0;
    logic power_good_in = 1'h0, thermal_regulation_in = 1'h0, system_minimum_in = 1'h0;
    logic watchdog_expired_in = 1'h1, boost_overload_in = 1'h0, boost_battery_low_in = 1'h0;
    logic input_fault_in = 1'h0, thermal_shutdown_in = 1'h0, safety_timer_expired_in = 1'h0;
    logic battery_overvoltage_in = 1'h0;
    logic [2:0] thermistor_zone_in = 3'h0;
    logic input_qualified_in = 1'h0, input_voltage_loop_in = 1'h0, input_current_loop_in = 1'h0;
    logic sense_pin_fault_in = 1'h0, topoff_timer_running_in = 1'h0, input_overvoltage_in = 1'h0;
    logic irq_pulse_out, safety_timer_restart_out, register_reset_out;
    logic [2:0] zones [5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6};
    int failures = 0, checks_done = 0, i, n;
    int resets_seen = 0, restarts_seen = 0;
    ////////////////////////////////////////////////////////////////////////////////
    csr_charger_status_register_bank uut (.*);
    csr_host_model host (.sys_clk_in(sys_clk_in), .addr_out(reg_addr_in), .wr_out(reg_wr_in),
        .rd_out(reg_rd_in), .wdata_out(reg_wdata_in), .rdata_in(reg_rdata_out),
        .rvalid_in(reg_rvalid_out));
    always #20 sys_clk_in = ~sys_clk_in;
    // Pulse counters on the far edge, where the registered outputs are settled
    always @(negedge sys_clk_in) begin
        resets_seen += int'(register_reset_out === 1'h1);
        restarts_seen += int'(safety_timer_restart_out === 1'h1);
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            failures++;
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, got);
        chk($sformatf("register %h", a), exp, got);
    endtask
    // Two synchroniser edges and two code qualifier edges before the read sample
    task automatic settle;
        repeat (4) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        report_and_stop;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge sys_clk_in);
        #1 rstn_in = 1'h1;
        @(posedge sys_clk_in) #1;
        rd_chk(8'h09, 8'h80);
        for (i = 0; i < 4; i++) begin
            {input_present_in, source_select_pin_in, boost_active_in} = {i != 0, i == 1, i == 3};
            charge_phase_in = i[1:0];
            {power_good_in, thermal_regulation_in, system_minimum_in} = {i[0], i[1], ~i[0]};
            settle;
            rd_chk(8'h08, {3'((1 << i) - 1), i[1:0], i[0], i[1], ~i[0]});
        end
        host.write_reg(8'h08, 8'h00);
        rd_chk(8'h08, 8'hfe);
        $display("test status byte done");
        boost_active_in = 1'h0;
        for (i = 0; i < 5; i++) begin
            {watchdog_expired_in, boost_overload_in, boost_battery_low_in} = {i[0], i == 1, i == 2};
            {input_fault_in, thermal_shutdown_in} = {i >= 1 && i <= 3, i == 2};
            {safety_timer_expired_in, battery_overvoltage_in} = {i == 2 || i == 3, i[1]};
            thermistor_zone_in = zones[i];
            settle;
            rd_chk(8'h09, {i[0], i == 1 || i == 2, i[1:0], i[1], zones[i]});
        end
        {boost_active_in, thermistor_zone_in} = 4'ha;
        settle;
        rd_chk(8'h09, 8'h00);
        thermistor_zone_in = 3'h6;
        settle;
        rd_chk(8'h09, 8'h06);
        boost_active_in = 1'h0;
        $display("test fault byte done");
        host.write_reg(8'h0a, 8'hff);
        for (i = 0; i < 2; i++) begin
            {input_qualified_in, input_voltage_loop_in, input_current_loop_in, sense_pin_fault_in,
                topoff_timer_running_in, input_overvoltage_in} = i ? 6'h12 : 6'h2d;
            settle;
            rd_chk(8'h0a, i ? 8'h4b : 8'hb7);
        end
        host.write_reg(8'h0b, 8'h7f);
        rd_chk(8'h0a, 8'h4b);
        chk("reset pulses", 8'h00, 8'(resets_seen));
        host.write_reg(8'h0b, 8'h80);
        chk("reset pulses", 8'h01, 8'(resets_seen));
        chk("timer restarts", 8'h01, 8'(restarts_seen));
        rd_chk(8'h0b, 8'h04);
        rd_chk(8'h0c, 8'h00);
        rd_chk(8'h0a, 8'h48);
        $display("test status two done");
        {input_voltage_loop_in, input_current_loop_in} = 2'h0;
        settle;
        for (i = 0; i < 4; i++) begin
            host.write_reg(8'h0a, i[1] ? (i[0] ? 8'h01 : 8'h02) : 8'h00);
            if (i[0]) input_current_loop_in = 1'h1;
            else input_voltage_loop_in = 1'h1;
            n = 0;
            repeat (8) begin
                @(negedge sys_clk_in);
                if (irq_pulse_out === 1'h1) n++;
            end
            chk("interrupt pulses", 8'(!i[1]), 8'(n));
            @(posedge sys_clk_in) #1;
            {input_voltage_loop_in, input_current_loop_in} = 2'h0;
            settle;
        end
        $display("test interrupt masks done");
        report_and_stop;
    end
endmodule // testbench

bind csr_charger_status_register_bank csr_bank_properties #(.ADDR_W(ADDR_W)) chk_props (.*);
